// [bench/tb_zone_lock_and_ephemeral_key.sv]
`timescale 1ns/10ps
`include "zlk_map.svh"
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module tb_zone_lock_and_ephemeral_key;
    import zlk_pkg::*;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] msk;
        logic [1:0] resp;
    } zlk_note_s;
    localparam logic [7:0] a_st = `ZLK_ADDR_STATUS;
    localparam logic [7:0] a_ks = `ZLK_ADDR_KEYSTAT;
    localparam logic [31:0] f_org = 32'h0000_0400;
    localparam logic [31:0] f_vrf = 32'h0000_0800;
    localparam logic [31:0] f_crc = 32'h0000_1000;
    localparam logic [31:0] f_exe = 32'h0000_2000;
    localparam logic [31:0] f_cpy = 32'h0000_4000;
    localparam logic [31:0] f_fix = 32'h0000_8000;
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    logic [3:0] evt = 4'h0;
    logic [255:0] key_data = 256'h0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, key_ok;
    logic [255:0] key_out;
    logic [31:0] rd_dump;
    zlk_note_s notes[$];
    int err_count = 0;
    int num_checks = 0;
    int seed = 32'h0C71;

    always #5 CLOCK = ~CLOCK;

    zlk_zone_lock dut (.CLOCK(CLOCK), .NRST(NRST), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .SLEEP_EVT(evt[0]), .BROWNOUT_EVT(evt[1]),
        .WATCHDOG_EVT(evt[2]), .TAMPER_EVT(evt[3]),
        .KEY_DATA(key_data), .CRYPT_KEY_VALID(key_ok),
        .CRYPT_KEY(key_out));
    zlk_host host (.clock(CLOCK), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // read monitor: oldest note against each completed read
    always @(posedge CLOCK) begin
        zlk_note_s n;
        if (rvalid && rready) begin
            n = notes.pop_front();
            if (n.msk != 32'h0) `CHK(rdata & n.msk, n.exp)
            `CHK(rresp, n.resp)
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] rs, output logic [31:0] d);
        logic [1:0] r;
        notes.push_back('{e, m, rs});
        host.rd(a, d, r);
    endtask : rd

    task automatic chk(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        logic [31:0] d;
        rd(a, e, m, `ZLK_RESP_OKAY, d);
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] rs);
        logic [1:0] r;
        host.wr(a, d, r);
        `CHK(r, rs)
    endtask : wr

    function automatic logic [31:0] mk(zlk_op_e o, zlk_zone_e z,
        logic [3:0] s, logic [31:0] f);
        return f | {22'h0, s, z, o};
    endfunction : mk

    // issue a command and poll until the sequencer is idle again
    task automatic cmd(input logic [31:0] c);
        logic [31:0] d;
        wr(`ZLK_ADDR_CMD, c, `ZLK_RESP_OKAY);
        repeat (4) @(posedge CLOCK);
        d = 32'h0000_0060;
        for (int i = 0; i < 50 && d[6:5] != 2'b00; i++) begin
            rd(a_st, 32'h0, 32'h0, `ZLK_RESP_OKAY, d);
        end
        if (d[6:5] !== 2'b00) begin
            err_count++;
            $display("ERROR %0t: command never finished", $time);
        end
        repeat (2) @(posedge CLOCK);
    endtask : cmd

    task automatic nk();
        @(posedge CLOCK);
        for (int i = 0; i < 8; i++) begin
            key_data[i*32 +: 32] <= $random(seed);
        end
    endtask : nk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge CLOCK);
        NRST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        chk(`ZLK_ADDR_LOCKS, 32'h0000_5555, 32'h0000_FFFF);
        chk(`ZLK_ADDR_EVENT, 32'h0000_00AA, 32'h0000_00FF);
        chk(a_ks, 32'h0, 32'h0000_0001);
        rd(8'h18, 32'h0, 32'h0, `ZLK_RESP_SLVERR, rd_dump);
        wr(`ZLK_ADDR_LOCKS, 32'h0, `ZLK_RESP_SLVERR);
        chk(`ZLK_ADDR_LOCKS, 32'h0000_5555, 32'h0000_FFFF);
        $display("test reset and map done");
        nk();
        cmd(mk(ZLK_OP_DIGEST, ZLK_ZONE_DATA, 4'h5, f_vrf));
        chk(a_ks, 32'h0000_0057, 32'h0000_00F7);
        `CHK(key_out, key_data)
        nk();
        cmd(mk(ZLK_OP_NONCE, ZLK_ZONE_CONFIG, 4'h0, f_org));
        chk(a_ks, 32'h0000_0009, 32'h0000_000F);
        `CHK(key_out, key_data)
        `CHK(key_ok, 1'b1)
        cmd(mk(ZLK_OP_DIGEST, ZLK_ZONE_DATA, 4'h2, f_crc));
        chk(a_ks, 32'h1, 32'h1);
        cmd(mk(ZLK_OP_MACVERIFY, ZLK_ZONE_DATA, 4'h2, f_cpy));
        chk(a_ks, 32'h1, 32'h1);
        cmd(mk(ZLK_OP_DIGEST, ZLK_ZONE_DATA, 4'h2, f_exe));
        chk(a_ks, 32'h0, 32'h1);
        cmd(mk(ZLK_OP_NONCE, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
        cmd(mk(ZLK_OP_OTHER, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
        chk(a_ks, 32'h0, 32'h1);
        `CHK(key_ok, 1'b0)
        $display("test key flags done");
        for (int i = 0; i < 4; i++) begin
            nk();
            cmd(mk(ZLK_OP_NONCE, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
            repeat (20) @(posedge CLOCK);
            `CHK(key_ok, 1'b1)
            evt[i] <= 1'b1;
            @(posedge CLOCK);
            evt <= 4'h0;
            repeat (6) @(posedge CLOCK);
            `CHK(key_ok, 1'b0)
            chk(a_ks, 32'h0, 32'h1);
        end
        $display("test events done");
        cmd(mk(ZLK_OP_READ, ZLK_ZONE_DATA, 4'h3, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_OTP, 4'h0, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_CONFIG, 4'h0, f_fix));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
        chk(a_st, 32'h0, 32'hF);
        wr(`ZLK_ADDR_ACCESS, 32'h0000_0008, `ZLK_RESP_OKAY);
        cmd(mk(ZLK_OP_LOCK_CFG, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
        chk(`ZLK_ADDR_LOCKS, 32'h0000_0055, 32'h0000_FFFF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_CONFIG, 4'h0, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        wr(`ZLK_ADDR_ACCESS, 32'hFFFF_FFFF, `ZLK_RESP_OKAY);
        chk(`ZLK_ADDR_ACCESS, 32'h0000_0008, 32'hFFFF_FFFF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_DATA, 4'h4, 32'h0));
        chk(a_st, 32'h0, 32'hF);
        cmd(mk(ZLK_OP_READ, ZLK_ZONE_DATA, 4'h3, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_LOCK_DATA, ZLK_ZONE_DATA, 4'h0, 32'h0));
        chk(`ZLK_ADDR_LOCKS, 32'h0, 32'h0000_FFFF);
        cmd(mk(ZLK_OP_READ, ZLK_ZONE_DATA, 4'h3, 32'h0));
        chk(a_st, 32'h0, 32'hF);
        cmd(mk(ZLK_OP_READ, ZLK_ZONE_DATA, 4'h4, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_DATA, 4'h3, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        cmd(mk(ZLK_OP_WRITE, ZLK_ZONE_OTP, 4'h0, 32'h0));
        chk(a_st, 32'h1, 32'hF);
        $display("test zone locking done");
        end_of_test();
    end
endmodule : tb_zone_lock_and_ephemeral_key

// [bench/zlk_host.sv]
`timescale 1ns/10ps
// host side: axi4-lite master, one transfer at a time
module zlk_host (
    input wire logic clock,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge clock);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : zlk_host

// [common/zlk_key_if.sv]
`timescale 1ns/10ps
interface zlk_key_if;
    logic load;
    logic clear;
    logic [255:0] wdata;
    logic [3:0] slot;
    logic origin;
    logic derived;
    logic verify_only;
    logic valid;
    logic [255:0] key;
    logic [3:0] key_slot;
    logic key_origin;
    logic key_derived;
    logic key_verify_only;
    modport ctrl(output load, clear, wdata, slot, origin, derived,
        verify_only, input valid, key, key_slot, key_origin, key_derived,
        key_verify_only);
    modport store(input load, clear, wdata, slot, origin, derived,
        verify_only, output valid, key, key_slot, key_origin, key_derived,
        key_verify_only);
endinterface : zlk_key_if

// [common/zlk_map.svh]
`ifndef ZLK_MAP_SVH
`define ZLK_MAP_SVH
// register byte addresses
`define ZLK_ADDR_LOCKS 8'h00
`define ZLK_ADDR_CMD 8'h04
`define ZLK_ADDR_STATUS 8'h08
`define ZLK_ADDR_KEYSTAT 8'h0C
`define ZLK_ADDR_ACCESS 8'h10
`define ZLK_ADDR_EVENT 8'h14
// lock byte positions in the configuration zone
`define ZLK_DATA_OTP_LOCK_IDX 8'h56
`define ZLK_CONFIG_LOCK_IDX 8'h57
`define ZLK_UNLOCKED 8'h55
`define ZLK_LOCKED 8'h00
// fixed configuration bytes 0..12
`define ZLK_FIXED_LAST 8'h0C
// otp mode byte: reset value and the code that allows otp writes
`define ZLK_OTP_MODE_RESET 8'hAA
`define ZLK_OTP_CONSUME 8'h55
// error codes
`define ZLK_ERR_NONE 4'h0
`define ZLK_ERR_REFUSED 4'h1
`define ZLK_ERR_EXEC 4'h2
`define ZLK_RESP_OKAY 2'b00
`define ZLK_RESP_SLVERR 2'b10
`endif

// [common/zlk_pkg.sv]
package zlk_pkg;
    typedef enum logic [3:0] {
        ZLK_OP_NONE = 4'h0,
        ZLK_OP_NONCE = 4'h1,
        ZLK_OP_DIGEST = 4'h2,
        ZLK_OP_MACVERIFY = 4'h3,
        ZLK_OP_LOCK_CFG = 4'h4,
        ZLK_OP_LOCK_DATA = 4'h5,
        ZLK_OP_READ = 4'h6,
        ZLK_OP_WRITE = 4'h7,
        ZLK_OP_OTHER = 4'h8
    } zlk_op_e;
    typedef enum logic [1:0] {
        ZLK_ZONE_CONFIG = 2'h0,
        ZLK_ZONE_DATA = 2'h1,
        ZLK_ZONE_OTP = 2'h2
    } zlk_zone_e;
    typedef enum logic [1:0] {
        ZLK_ST_IDLE = 2'b00,
        ZLK_ST_EXEC = 2'b01,
        ZLK_ST_DONE = 2'b11
    } zlk_state_e;
endpackage : zlk_pkg

// [verilog/zlk_key_store.sv]
`timescale 1ns/10ps
// ephemeral key register with its flags, invalidated on clear unless a load comes in the same cycle
module zlk_key_store (
    input wire logic CLOCK,
    input wire logic NRST,
    zlk_key_if.store kif
);
    logic [255:0] key_r;
    logic [3:0] slot_r;
    logic origin_r;
    logic derived_r;
    logic vonly_r;
    logic valid_r;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            key_r <= '0;
            slot_r <= 4'h0;
            origin_r <= 1'b0;
            derived_r <= 1'b0;
            vonly_r <= 1'b0;
        end else if (kif.load) begin
            key_r <= kif.wdata;
            slot_r <= kif.slot;
            origin_r <= kif.origin;
            derived_r <= kif.derived;
            vonly_r <= kif.verify_only;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            valid_r <= 1'b0;
        end else if (kif.load) begin
            valid_r <= 1'b1;
        end else if (kif.clear) begin
            valid_r <= 1'b0;
        end
    end

    assign kif.key = key_r;
    assign kif.key_slot = slot_r;
    assign kif.key_origin = origin_r;
    assign kif.key_derived = derived_r;
    assign kif.key_verify_only = vonly_r;
    assign kif.valid = valid_r;

    chk_load_sets_valid: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        kif.load |=> valid_r)
        else $error("load did not set valid");
endmodule : zlk_key_store

// [verilog/zlk_zone_lock.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "zlk_map.svh"
module zlk_zone_lock
    import zlk_pkg::*;
#(
    parameter int SLOTS = 16
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic SLEEP_EVT,
    input wire logic BROWNOUT_EVT,
    input wire logic WATCHDOG_EVT,
    input wire logic TAMPER_EVT,
    input wire logic [255:0] KEY_DATA,
    output logic CRYPT_KEY_VALID,
    output logic [255:0] CRYPT_KEY
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] config_lock_byte_r;
    logic [7:0] data_otp_lock_byte_r;
    logic [7:0] otp_mode_r;
    logic [SLOTS-1:0] slot_rd_ok_r;
    logic [SLOTS-1:0] slot_wr_ok_r;
    logic [31:0] cmd_r;
    logic [3:0] err_r;
    logic allow_r;
    logic wipe_r;
    zlk_state_e state_r;
    logic [2:0] ev_s1_r;
    logic [2:0] ev_s2_r;
    logic slp_s1_r;
    logic slp_s2_r;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic cmd_go;
    zlk_key_if kif();

    zlk_key_store u_key (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .kif(kif)
    );

    ////////////////////////////////////////////////////////////////////////
    // event pins pass two flip-flops
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ev_s1_r <= 3'h0;
            ev_s2_r <= 3'h0;
            slp_s1_r <= 1'b0;
            slp_s2_r <= 1'b0;
        end else begin
            ev_s1_r <= {BROWNOUT_EVT, WATCHDOG_EVT, TAMPER_EVT};
            ev_s2_r <= ev_s1_r;
            slp_s1_r <= SLEEP_EVT;
            slp_s2_r <= slp_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command word: [3:0] op, [5:4] zone, [9:6] slot, [10] origin,
    // [11] verify restricted slot bit, [12] crc error, [13] exec error,
    // [14] copy success, [15] fixed config byte addressed
    zlk_op_e op;
    zlk_zone_e zone;
    logic [3:0] slot;
    logic is_write;
    logic cfg_unl;
    logic dat_unl;
    logic ok;
    assign op = zlk_op_e'(cmd_r[3:0]);
    assign zone = zlk_zone_e'(cmd_r[5:4]);
    assign slot = cmd_r[9:6];
    assign is_write = (op == ZLK_OP_WRITE);
    assign cfg_unl = (config_lock_byte_r == `ZLK_UNLOCKED);
    assign dat_unl = (data_otp_lock_byte_r == `ZLK_UNLOCKED);

    // access decision evaluated before anything changes
    always_comb begin
        ok = 1'b1;
        if (op == ZLK_OP_READ || op == ZLK_OP_WRITE) begin
            if (zone == ZLK_ZONE_CONFIG) begin
                ok = !is_write || (cfg_unl && !cmd_r[15]);
            end else if (cfg_unl) begin
                ok = 1'b0;
            end else if (dat_unl) begin
                ok = is_write;
            end else if (zone == ZLK_ZONE_DATA) begin
                // per-slot permissions once data is locked
                ok = is_write ? slot_wr_ok_r[slot] : slot_rd_ok_r[slot];
            end else begin
                // otp mode: 0xAA read only, 0x55 consumption
                ok = is_write ? (otp_mode_r == `ZLK_OTP_CONSUME) : 1'b1;
            end
            if (cmd_r[11] == 1'b0 && !kif.valid && cmd_r[13]) begin
                ok = 1'b0; // protected transfer needs a valid key
            end
        end else if (op == ZLK_OP_LOCK_CFG) begin
            ok = cfg_unl;
        end else if (op == ZLK_OP_LOCK_DATA) begin
            ok = !cfg_unl && dat_unl;
        end else if (op == ZLK_OP_NONCE || op == ZLK_OP_DIGEST) begin
            ok = !cmd_r[13];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state_r <= ZLK_ST_IDLE;
        end else begin
            case (state_r)
                ZLK_ST_IDLE: begin
                    if (cmd_go) begin
                        state_r <= ZLK_ST_EXEC;
                    end
                end
                ZLK_ST_EXEC: begin
                    state_r <= ZLK_ST_DONE;
                end
                ZLK_ST_DONE: begin
                    state_r <= ZLK_ST_IDLE;
                end
                default: begin
                    state_r <= ZLK_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            err_r <= `ZLK_ERR_NONE;
            allow_r <= 1'b0;
        end else if (state_r == ZLK_ST_EXEC && !cmd_r[12]) begin
            allow_r <= ok;
            err_r <= ok ? `ZLK_ERR_NONE : `ZLK_ERR_REFUSED;
        end
    end

    // lock bytes change only here, only toward locked
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            config_lock_byte_r <= `ZLK_UNLOCKED;
            data_otp_lock_byte_r <= `ZLK_UNLOCKED;
        end else if (state_r == ZLK_ST_EXEC && !cmd_r[12] && ok) begin
            if (op == ZLK_OP_LOCK_CFG) begin
                config_lock_byte_r <= `ZLK_LOCKED;
            end else if (op == ZLK_OP_LOCK_DATA) begin
                data_otp_lock_byte_r <= `ZLK_LOCKED;
            end
        end
    end

    // slot permissions and otp mode: config zone contents
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            slot_rd_ok_r <= '0;
            slot_wr_ok_r <= '0;
            otp_mode_r <= `ZLK_OTP_MODE_RESET;
        end else if (aw_got_r && w_got_r && awaddr_r == `ZLK_ADDR_ACCESS
                     && cfg_unl) begin
            slot_rd_ok_r <= wdata_r[15:0];
            slot_wr_ok_r <= wdata_r[31:16];
        end else if (aw_got_r && w_got_r && awaddr_r == `ZLK_ADDR_EVENT
                     && cfg_unl) begin
            otp_mode_r <= wdata_r[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ephemeral key updates
    logic exec_now;
    assign exec_now = (state_r == ZLK_ST_EXEC) && !cmd_r[12];
    assign kif.wdata = KEY_DATA;
    assign kif.slot = slot;
    assign kif.origin = cmd_r[10];
    assign kif.derived = (op == ZLK_OP_DIGEST);
    assign kif.verify_only = (op == ZLK_OP_DIGEST) && cmd_r[11];
    // nonce and digest overwrite each other
    assign kif.load = exec_now && ok
        && (op == ZLK_OP_NONCE || op == ZLK_OP_DIGEST);

    always_comb begin
        kif.clear = 1'b0;
        if (slp_s2_r || (|ev_s2_r) || wipe_r) begin
            kif.clear = 1'b1;
        end else if (exec_now) begin
            if (op == ZLK_OP_NONCE || op == ZLK_OP_DIGEST) begin
                kif.clear = !ok;
            end else if (op == ZLK_OP_MACVERIFY) begin
                kif.clear = !cmd_r[14];
            end else begin
                kif.clear = 1'b1;
            end
        end
    end

    // wipe pulse after sleep also drops the command buffer
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            wipe_r <= 1'b1;
        end else begin
            wipe_r <= slp_s2_r;
        end
    end

    // key is exposed only to the crypt datapath, never to the bus
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            CRYPT_KEY <= '0;
            CRYPT_KEY_VALID <= 1'b0;
        end else begin
            CRYPT_KEY <= kif.key;
            CRYPT_KEY_VALID <= kif.valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
        end else if (aw_got_r && w_got_r) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_got_r <= 1'b1;
                awaddr_r <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_r <= 1'b1;
                wdata_r <= WDATA;
            end
        end
    end

    assign cmd_go = aw_got_r && w_got_r && awaddr_r == `ZLK_ADDR_CMD
        && state_r == ZLK_ST_IDLE;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            cmd_r <= 32'h0000_0000;
        end else if (wipe_r) begin
            cmd_r <= 32'h0000_0000;
        end else if (cmd_go) begin
            cmd_r <= wdata_r;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `ZLK_RESP_OKAY;
        end else begin
            AWREADY <= !aw_got_r && !(AWVALID && AWREADY) && !BVALID;
            WREADY <= !w_got_r && !(WVALID && WREADY) && !BVALID;
            if (aw_got_r && w_got_r) begin
                BVALID <= 1'b1;
                if (awaddr_r == `ZLK_ADDR_CMD || awaddr_r == `ZLK_ADDR_ACCESS
                    || awaddr_r == `ZLK_ADDR_EVENT) begin
                    BRESP <= `ZLK_RESP_OKAY;
                end else begin
                    BRESP <= `ZLK_RESP_SLVERR;
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= `ZLK_RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP <= `ZLK_RESP_OKAY;
                if (ARADDR == `ZLK_ADDR_LOCKS) begin
                    RDATA <= {16'h0000, config_lock_byte_r,
                        data_otp_lock_byte_r};
                end else if (ARADDR == `ZLK_ADDR_CMD) begin
                    RDATA <= cmd_r;
                end else if (ARADDR == `ZLK_ADDR_STATUS) begin
                    RDATA <= {25'h0, state_r, allow_r, err_r};
                end else if (ARADDR == `ZLK_ADDR_KEYSTAT) begin
                    RDATA <= {24'h0, kif.key_slot, kif.key_origin,
                        kif.key_derived, kif.key_verify_only, kif.valid};
                end else if (ARADDR == `ZLK_ADDR_ACCESS) begin
                    RDATA <= {slot_wr_ok_r, slot_rd_ok_r};
                end else if (ARADDR == `ZLK_ADDR_EVENT) begin
                    RDATA <= {24'h0, otp_mode_r};
                end else begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= `ZLK_RESP_SLVERR;
                end
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_lock_one_way: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        config_lock_byte_r != `ZLK_UNLOCKED |=>
        config_lock_byte_r != `ZLK_UNLOCKED)
        else $error("config lock reopened");
    chk_data_lock_way: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        data_otp_lock_byte_r != `ZLK_UNLOCKED |=>
        data_otp_lock_byte_r != `ZLK_UNLOCKED)
        else $error("data lock reopened");
    chk_cfg_write_refused: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (exec_now && op == ZLK_OP_WRITE && zone == ZLK_ZONE_CONFIG
        && !cfg_unl) |=> err_r == `ZLK_ERR_REFUSED)
        else $error("locked config write accepted");
    chk_data_before_cfg: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (exec_now && (op == ZLK_OP_READ || op == ZLK_OP_WRITE)
        && zone != ZLK_ZONE_CONFIG && cfg_unl) |=> !allow_r)
        else $error("data access before config lock");
    chk_unlocked_read: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (exec_now && op == ZLK_OP_READ && zone != ZLK_ZONE_CONFIG
        && dat_unl) |=> !allow_r)
        else $error("read of unlocked data zone");
    chk_other_clears: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (exec_now && op == ZLK_OP_OTHER) |=> ##1 !CRYPT_KEY_VALID)
        else $error("other command kept key valid");
    // synchronised tamper clears valid, seen on the output one edge later
    chk_event_clears: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        ev_s2_r[0] |=> ##1 !CRYPT_KEY_VALID)
        else $error("tamper did not clear key");
    chk_crc_keeps_key: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (state_r == ZLK_ST_EXEC && cmd_r[12] && kif.valid && !wipe_r
        && !slp_s2_r && ev_s2_r == 3'h0) |=> kif.valid)
        else $error("crc error cleared key");
    chk_nonce_sets: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (exec_now && ok && op == ZLK_OP_NONCE && !slp_s2_r) |=>
        kif.valid && !kif.key_derived)
        else $error("nonce did not load key");
endmodule : zlk_zone_lock
